//--- common/mtc_pkg.sv
// Shared constants and types of the MAC transmit capture stage.
// Assumes one core clock domain and one interface clock domain.
`default_nettype none

package mtc_pkg;

    // Interface widths per mode
    localparam int unsigned MII_DATA_W    = 4;
    localparam int unsigned RMII_DATA_W   = 2;

    // Nominal transfer rates per mode, and the core clock rate
    localparam int unsigned MII_RATE_MHZ  = 25;
    localparam int unsigned RMII_RATE_MHZ = 50;
    localparam int unsigned CORE_CLK_MHZ  = 50;

    // Depth of every synchroniser
    localparam int unsigned SYNC_STAGES   = 2;

    // Interface mode, as caught from the strap
    typedef enum logic {
        MTC_MODE_MII  = 1'b0,
        MTC_MODE_RMII = 1'b1
    } mtc_mode_t;

    // Values after reset
    localparam mtc_mode_t                MODE_RST  = MTC_MODE_MII;
    localparam logic [MII_DATA_W-1:0]    DATA_RST  = 4'h0;
    localparam logic                     VALID_RST = 1'b0;
    localparam logic                     RST_ACTIVE = 1'b1;

endpackage : mtc_pkg

`default_nettype wire

//--- logic/mtc_sync.sv
// Multi-bit level synchroniser, one chain of flip-flops per bit.
// Assumes each bit is an independent level; no reset, so the
// destination clock must run while the source settles.
`default_nettype none

module mtc_sync #(
    parameter int unsigned WIDTH  = 1,
    parameter int unsigned STAGES = mtc_pkg::SYNC_STAGES
) (
    input  wire logic             clk_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    import mtc_pkg::*;

    logic [WIDTH-1:0] stage_q [STAGES];

    // Refuse chains too short to settle metastability
    if (STAGES < 2) begin : g_bad_stages
        $error("mtc_sync needs at least two stages");
    end

    // First stage is read only by the next stage
    always_ff @(posedge clk_i) begin
        stage_q[0] <= async_i;
    end

    // Remaining stages of the chain
    for (genvar s = 1; s < STAGES; s++) begin : g_stage
        always_ff @(posedge clk_i) begin
            stage_q[s] <= stage_q[s-1];
        end
    end

    assign sync_o = stage_q[STAGES-1];

endmodule // mtc_sync

`default_nettype wire

//--- logic/mtc_capture.sv
// Transmit capture stage between a MAC and the transmit encoder.
// Assumes the MAC drives data and enable synchronous to the interface
// clock (the nibble clock in MII mode, the reference clock in RMII
// mode) and that this clock runs across reset.
`default_nettype none

// Functional notes
// [RULE_01] MAC places transmit data and holds enable high while data is valid.
// [RULE_02] In MII mode sample data and enable on every interface clock rising edge.
// [RULE_03] MII transfers carry a 4-bit nibble each, at a 25 MHz rate.
// [RULE_04] In RMII mode sample data and enable on every reference clock rising edge.
// [RULE_05] RMII transfers carry a 2-bit dibit each, at a 50 MHz rate.
// [RULE_06] Catch the mode strap during reset and keep it until the next reset.
// [RULE_07] The external system reset is active low and resets the capture logic.
// [RULE_08] Pass each captured unit with its enable-derived valid flag to the encoder.
module mtc_capture #(
    parameter int unsigned DATA_W = mtc_pkg::MII_DATA_W
) (
    input  wire logic                           core_clk_i,
    input  wire logic                           sys_rst_i,
    input  wire logic                           system_reset_n_i,
    input  wire logic                           reduced_interface_select_strap_i,
    input  wire logic                           tx_if_clk_i,
    input  wire logic [mtc_pkg::MII_DATA_W-1:0] mac_txd_i,
    input  wire logic                           mac_tx_en_i,
    output logic      [mtc_pkg::MII_DATA_W-1:0] enc_data_o,
    output logic                                enc_valid_o,
    output logic                                enc_rmii_o,
    output logic                                mode_rmii_o,
    output logic                                tx_active_o
);
    import mtc_pkg::*;

    // Refuse a data width the capture path cannot serve
    if (DATA_W != MII_DATA_W) begin : g_bad_width
        $error("mtc_capture supports only the MII data width");
    end

    // ------------------------------------------------------------
    // Core clock domain
    // ------------------------------------------------------------

    logic [2:0]  core_sync_w;
    logic        strap_sync_w;
    logic        system_reset_n_sync_w;
    logic        active_sync_w;
    logic        core_rst_d;
    logic        core_rst_q;
    mtc_mode_t   mode_d;
    mtc_mode_t   mode_q;

    // Strap, reset pin and link activity enter through two flops
    mtc_sync #(
        .WIDTH  (3),
        .STAGES (SYNC_STAGES)
    ) u_core_sync (
        .clk_i   (core_clk_i),
        .async_i ({enc_valid_o, system_reset_n_i, reduced_interface_select_strap_i}),
        .sync_o  (core_sync_w)
    );

    assign strap_sync_w  = core_sync_w[0];
    assign system_reset_n_sync_w   = core_sync_w[1];
    assign active_sync_w = core_sync_w[2];

    // Either reset source holds the block in reset
    assign core_rst_d = sys_rst_i | ~system_reset_n_sync_w;              // RULE_07

    // Strap is followed throughout reset and frozen at release
    assign mode_d = core_rst_d ? mtc_mode_t'(strap_sync_w) : mode_q; // RULE_06

    // Reset flag and mode register
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            core_rst_q <= RST_ACTIVE;
            mode_q     <= mode_d;
        end else begin
            core_rst_q <= core_rst_d;
            mode_q     <= mode_d;
        end
    end

    // Core-side status outputs
    always_ff @(posedge core_clk_i) begin
        if (core_rst_d) begin
            tx_active_o <= VALID_RST;
        end else begin
            tx_active_o <= active_sync_w;
        end
    end

    assign mode_rmii_o = (mode_q == MTC_MODE_RMII);

    // ------------------------------------------------------------
    // Interface clock domain
    // ------------------------------------------------------------

    logic [1:0]            link_sync_w;
    logic                  link_rst_w;
    logic                  link_mode_sync_w;
    logic                  link_rmii_q;
    logic [MII_DATA_W-1:0] rmii_mask_w;
    logic [MII_DATA_W-1:0] data_d;

    // Reset flag and mode cross as levels
    mtc_sync #(
        .WIDTH  (2),
        .STAGES (SYNC_STAGES)
    ) u_link_sync (
        .clk_i   (tx_if_clk_i),
        .async_i ({mode_rmii_o, core_rst_q}),
        .sync_o  (link_sync_w)
    );

    assign link_rst_w       = link_sync_w[0];                  // RULE_07
    assign link_mode_sync_w = link_sync_w[1];

    // Mode held on the link side, updated only under reset
    always_ff @(posedge tx_if_clk_i) begin
        if (link_rst_w) begin
            link_rmii_q <= link_mode_sync_w;                   // RULE_06
        end
    end

    // Dibit mode keeps only the low two data lines
    assign rmii_mask_w = link_rmii_q ? {{(MII_DATA_W-RMII_DATA_W){1'b0}}, {RMII_DATA_W{1'b1}}}
                                     : {MII_DATA_W{1'b1}};      // RULE_03 RULE_05

    // Idle cycles hand a zero word to the encoder
    assign data_d = mac_tx_en_i ? (mac_txd_i & rmii_mask_w) : DATA_RST; // RULE_01

    // Capture on every rising edge of the interface clock
    always_ff @(posedge tx_if_clk_i) begin
        if (link_rst_w) begin
            enc_data_o  <= DATA_RST;
            enc_valid_o <= VALID_RST;
        end else begin
            enc_data_o  <= data_d;                             // RULE_02 RULE_04
            enc_valid_o <= mac_tx_en_i;                        // RULE_08
        end
    end

    assign enc_rmii_o = link_rmii_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    // MII: captured nibble and valid follow the previous edge
    // The release edge still clears the outputs, so start only out of reset
    property p_mii_capture;                                    // RULE_02
        @(posedge tx_if_clk_i) disable iff (link_rst_w)
        (!link_rst_w && !link_rmii_q && mac_tx_en_i) |=>
            (enc_valid_o && enc_data_o == $past(mac_txd_i));
    endproperty
    a_mii_capture: assert property (p_mii_capture)             // RULE_02
        else $error("MII nibble not captured on the edge");

    // MII: back-to-back enables give back-to-back nibbles
    property p_mii_rate;                                       // RULE_03
        @(posedge tx_if_clk_i) disable iff (link_rst_w)
        (!link_rst_w && !link_rmii_q && mac_tx_en_i) [*2] |=>
            $past(enc_valid_o) && enc_valid_o;
    endproperty
    a_mii_rate: assert property (p_mii_rate)                   // RULE_03
        else $error("MII transfers not one per clock");

    // RMII: low dibit and valid captured on the edge
    property p_rmii_capture;                                   // RULE_04
        @(posedge tx_if_clk_i) disable iff (link_rst_w)
        (!link_rst_w && link_rmii_q && mac_tx_en_i) |=>
            (enc_valid_o && enc_data_o[1:0] == $past(mac_txd_i[1:0]));
    endproperty
    a_rmii_capture: assert property (p_rmii_capture)           // RULE_04
        else $error("RMII dibit not captured on the edge");

    // RMII: data never wider than a dibit
    property p_rmii_width;                                     // RULE_05
        @(posedge tx_if_clk_i) disable iff (link_rst_w)
        link_rmii_q ##1 link_rmii_q |-> enc_data_o[3:2] == 2'h0;
    endproperty
    a_rmii_width: assert property (p_rmii_width)               // RULE_05
        else $error("RMII output wider than two bits");

    // Strap followed during reset, from its third cycle on
    property p_strap_follow;                                   // RULE_06
        @(posedge core_clk_i) disable iff (1'b0)
        (core_rst_d && $past(core_rst_q)) |=> mode_q == $past(strap_sync_w);
    endproperty
    a_strap_follow: assert property (p_strap_follow)           // RULE_06
        else $error("Mode not following strap during reset");

    // Mode frozen outside reset
    property p_mode_hold;                                      // RULE_06
        @(posedge core_clk_i) disable iff (sys_rst_i)
        !core_rst_d |=> $stable(mode_q);
    endproperty
    a_mode_hold: assert property (p_mode_hold)                 // RULE_06
        else $error("Mode changed outside reset");

    // Low reset pin puts the core in reset and clears activity
    property p_pin_reset;                                      // RULE_07
        @(posedge core_clk_i) disable iff (sys_rst_i)
        !system_reset_n_sync_w |=> core_rst_q && !tx_active_o;
    endproperty
    a_pin_reset: assert property (p_pin_reset)                 // RULE_07
        else $error("Low reset pin did not reset the block");

    // Valid flag tracks the sampled enable, idle data zero
    property p_valid_flag;                                     // RULE_08
        @(posedge tx_if_clk_i) disable iff (link_rst_w)
        !mac_tx_en_i |=> !enc_valid_o && enc_data_o == 4'h0;
    endproperty
    a_valid_flag: assert property (p_valid_flag)               // RULE_08
        else $error("Valid set or data present without enable");

    // Link-side mode frozen outside link reset
    property p_link_mode_hold;                                 // RULE_06
        @(posedge tx_if_clk_i) disable iff (link_rst_w)
        !link_rst_w |=> $stable(link_rmii_q);
    endproperty
    a_link_mode_hold: assert property (p_link_mode_hold)       // RULE_06
        else $error("Link mode changed outside reset");

endmodule // mtc_capture

`default_nettype wire

//--- testbench/mtc_mac_model.sv
// MAC-side transmit model: drives data and enable on the interface clock.
// Assumes the interface clock runs freely, as a MAC's transmit clock does.
`default_nettype none

module mtc_mac_model (
    input  wire logic       tx_if_clk_i,
    output logic      [3:0] mac_txd_o,
    output logic            mac_tx_en_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        mac_txd_o   = 4'h0;
        mac_tx_en_o = 1'b0;
    end

    // One unit: launched on the falling edge, held through the next rising edge
    task automatic put(input logic [3:0] d, input logic en);
        @(negedge tx_if_clk_i);
        mac_tx_en_o = en;
        mac_txd_o   = d;
        @(posedge tx_if_clk_i);
    endtask
endmodule // mtc_mac_model

`default_nettype wire

//--- testbench/mtc_capture_tb.sv
// Self-checking bench of the transmit capture stage.
// Assumes the MAC model holds its last request between calls.
`default_nettype none

module mtc_capture_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       core_clk_i;
    logic       tx_if_clk_i;
    logic       sys_rst_i;
    logic       rst_n;
    logic       strap;
    logic [3:0] txd;
    logic       tx_en;
    logic [3:0] enc_data;
    logic       enc_valid;
    logic       enc_rmii;
    logic       mode_rmii;
    logic       tx_active;
    int         num_errors = 0;
    int         tests_run  = 0;
    int         cycles     = 0;

    mtc_capture #(.DATA_W(4)) mtc_capture_inst (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .system_reset_n_i(rst_n),
        .reduced_interface_select_strap_i(strap), .tx_if_clk_i(tx_if_clk_i),
        .mac_txd_i(txd), .mac_tx_en_i(tx_en), .enc_data_o(enc_data), .enc_valid_o(enc_valid),
        .enc_rmii_o(enc_rmii), .mode_rmii_o(mode_rmii), .tx_active_o(tx_active)
    );

    mtc_mac_model mtc_mac_model_inst (.tx_if_clk_i(tx_if_clk_i), .mac_txd_o(txd), .mac_tx_en_o(tx_en));

    // Core clock 20 ns, link clock 64 ns with an unrelated phase
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    initial begin
        tx_if_clk_i = 1'b0;
        #7;
        forever #32 tx_if_clk_i = ~tx_if_clk_i;
    end

    task automatic chk_data(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Core reset with the strap set, then time for the link reset to clear
    task automatic do_reset(input logic s);
        @(negedge core_clk_i);
        sys_rst_i = 1'b1;
        strap     = s;
        repeat (8) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        repeat (4) @(posedge tx_if_clk_i);
    endtask

    // One link transfer and its captured result
    task automatic xfer(input logic [3:0] d, input logic en, input logic [3:0] exp);
        mtc_mac_model_inst.put(d, en);
        #1;
        chk_data(enc_data, en ? exp : 4'h0);
        chk_flag(enc_valid, en);
    endtask

    task automatic test_mii();
        do_reset(1'b0);
        @(negedge core_clk_i);
        strap = 1'b1;
        for (int i = 0; i < 16; i++) xfer(4'(i), 1'b1, 4'(i));
        repeat (6) @(negedge core_clk_i);
        chk_flag(tx_active, 1'b1);
        xfer(4'ha, 1'b0, 4'h0);
        repeat (6) @(negedge core_clk_i);
        chk_flag(tx_active, 1'b0);
        chk_flag(mode_rmii, 1'b0);
        chk_flag(enc_rmii, 1'b0);
    endtask

    task automatic test_rmii();
        do_reset(1'b1);
        @(negedge core_clk_i);
        strap = 1'b0;
        for (int i = 0; i < 16; i++) xfer(4'(i), 1'b1, 4'(i) & 4'h3);
        xfer(4'h7, 1'b0, 4'h0);
        xfer(4'he, 1'b1, 4'h2);
        chk_flag(mode_rmii, 1'b1);
        chk_flag(enc_rmii, 1'b1);
    endtask

    task automatic test_pin_reset();
        mtc_mac_model_inst.put(4'h5, 1'b1);
        @(negedge core_clk_i);
        rst_n = 1'b0;
        repeat (16) @(negedge core_clk_i);
        chk_flag(mode_rmii, 1'b0);
        chk_flag(enc_valid, 1'b0);
        chk_flag(tx_active, 1'b0);
        rst_n = 1'b1;
        repeat (6) @(posedge tx_if_clk_i);
        xfer(4'h9, 1'b1, 4'h9);
        chk_flag(enc_rmii, 1'b0);
    endtask

    // Hang guard
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    // Main sequence
    initial begin
        sys_rst_i = 1'b1;
        rst_n     = 1'b1;
        strap     = 1'b0;
        repeat (2) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        test_mii();
        test_rmii();
        test_pin_reset();
        end_of_test();
    end
endmodule // mtc_capture_tb

`default_nettype wire
